// File: mdpp_dac_sink.sv
// DAC core model: accepts output beats, promptly or stalled, and counts them.
// Assumes the bench steers stall off the rising edge.
`timescale 1ns/100ps
module mdpp_dac_sink (
  input wire logic clock,
  input wire logic stall,
  input wire logic dacValid,
  output logic dacReady,
  input wire logic [15:0] dacI0,
  output int beats,
  output logic [15:0] lastI
);
  // ==========
  // Sink
  initial beats = 0;
  assign dacReady = !stall;
  always @(posedge clock)
    if (dacValid && dacReady)
    begin
      beats <= beats + 1;
      lastI <= dacI0;
    end
endmodule : mdpp_dac_sink

// File: mdpp_fifo.sv
// Sample FIFO with valid and ready on both sides and a synchronous flush.
// Assumes one clock; ready and valid come from flip-flops.
`timescale 1ns/100ps
module mdpp_fifo #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 8
)(
  input wire logic clock,
  input wire logic resetn,
  input wire logic flush,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] CNT_FULL = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH-1);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr;
  logic [AW-1:0] rdPtr;
  logic [AW:0] count;
  logic [AW:0] next_count;
  logic push;
  logic pop;

  assign push = inValid && inReady;
  assign pop = outValid && outReady;
  assign outData = mem[rdPtr];

  always_comb
  begin
    next_count = count;
    if (push && !pop)
      next_count = count + 1'b1;
    else if (pop && !push)
      next_count = count - 1'b1;
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
      inReady <= 1'b0;
      outValid <= 1'b0;
    end
    else if (flush)
    begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
      inReady <= 1'b1;
      outValid <= 1'b0;
    end
    else
    begin
      if (push)
        wrPtr <= (wrPtr == PTR_LAST) ? '0 : wrPtr + 1'b1;
      if (pop)
        rdPtr <= (rdPtr == PTR_LAST) ? '0 : rdPtr + 1'b1;
      count <= next_count;
      inReady <= (next_count != CNT_FULL);
      outValid <= (next_count != '0);
    end
  end

  always_ff @(posedge clock)
  begin
    if (push)
      mem[wrPtr] <= inData;
  end
endmodule : mdpp_fifo

// File: mdpp_params.svh
// Constants for the main datapath front end: register offsets, field positions, reset values.
// Assumes inclusion by bare name from every file that decodes registers or fields.
`ifndef MDPP_PARAMS_SVH
`define MDPP_PARAMS_SVH
// ==========================================
// Register offsets
`define MDPP_ADDR_PAGE 12'h008
`define MDPP_ADDR_LONG_EXP 12'h585
`define MDPP_ADDR_LONG_LIM_LO 12'h586
`define MDPP_ADDR_LONG_LIM_HI 12'h587
`define MDPP_ADDR_LONG_PWR_LO 12'h588
`define MDPP_ADDR_LONG_PWR_HI 12'h589
`define MDPP_ADDR_SHORT_EXP 12'h58a
`define MDPP_ADDR_SHORT_LIM_LO 12'h58b
`define MDPP_ADDR_SHORT_LIM_HI 12'h58c
`define MDPP_ADDR_SHORT_PWR_LO 12'h58d
`define MDPP_ADDR_SHORT_PWR_HI 12'h58e
`define MDPP_ADDR_MAIN_INTERP 12'h5f0
`define MDPP_ADDR_CHAN_INTERP 12'h5f1
`define MDPP_ADDR_PROTECT 12'h5f2
`define MDPP_ADDR_RAMP_EN 12'h5f3
`define MDPP_ADDR_IRQ_EN 12'h5f4
`define MDPP_ADDR_STATUS 12'h5f5
`define MDPP_ADDR_OUT_CTRL 12'h5f6
`define MDPP_ADDR_TX_CTRL 12'h5f7
// ==========================================
// Field positions
`define MDPP_PAGE_DP0_BIT 6
`define MDPP_EV_POWER 0
`define MDPP_EV_LINK 1
`define MDPP_EV_REG 2
`define MDPP_EV_BLANK 3
`define MDPP_OUT_ON_BIT 0
`define MDPP_OUT_QUICK_BIT 1
`define MDPP_TOP_BITS 6
`define MDPP_LONG_EXP_BIAS 5'h09
// ==========================================
// Reset values and gain scale
`define MDPP_PAGE_RESET 8'h40
`define MDPP_LIMIT_RESET 13'h1fff
`define MDPP_OUT_CTRL_RESET 2'h1
`define MDPP_GAIN_FULL 8'h80
`define MDPP_GAIN_SHIFT 7
// ==========================================
// Filter stage usable bandwidth (percent of input rate) and rejection (dB)
`define MDPP_BW_HB_FIRST 80
`define MDPP_BW_HB_SECOND 40
`define MDPP_BW_TB 27
`define MDPP_BW_HB_LAST 20
`define MDPP_STOP_BAND_DB 85
`endif

// File: mdpp_pkg.sv
// Types shared by the main datapath front end.
// Assumes nothing of its surroundings.
package mdpp_pkg;
  // ==========================================
  // Main interpolation factor, coded as the factor itself.
  typedef enum logic [3:0] {
    MDPP_X1 = 4'h1,
    MDPP_X2 = 4'h2,
    MDPP_X4 = 4'h4,
    MDPP_X6 = 4'h6,
    MDPP_X8 = 4'h8,
    MDPP_X12 = 4'hc
  } mdpp_interp_t;
endpackage : mdpp_pkg

// File: mdpp_top.sv
// Main datapath front end for two DAC datapaths: summing node, paged controls, protection
// triggers, power detection, output gain ramp and interpolation pacing.
// Assumes channel samples and register accesses on clock; pins arrive asynchronously.
`timescale 1ns/100ps
`include "mdpp_params.svh"
module mdpp_top #(
  parameter int SAMPLE_W = 16,
  parameter int CHANNELS = 3,
  parameter int FIFO_DEPTH = 8
)(
  input wire logic clock,
  input wire logic resetn,
  input wire logic regWrite,
  input wire logic [11:0] regAddr,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  input wire logic sampleValid,
  output logic sampleReady,
  input wire logic [CHANNELS*SAMPLE_W-1:0] chanI0,
  input wire logic [CHANNELS*SAMPLE_W-1:0] chanQ0,
  input wire logic [CHANNELS*SAMPLE_W-1:0] chanI1,
  input wire logic [CHANNELS*SAMPLE_W-1:0] chanQ1,
  input wire logic transmitEnableA,
  input wire logic transmitEnableB,
  input wire logic linkError,
  output logic dacValid,
  input wire logic dacReady,
  output logic [SAMPLE_W-1:0] dacI0,
  output logic [SAMPLE_W-1:0] dacQ0,
  output logic [SAMPLE_W-1:0] dacI1,
  output logic [SAMPLE_W-1:0] dacQ1,
  output logic interruptPinA_n,
  output logic interruptPinB_n
);
  localparam int WORD_W = 4 * SAMPLE_W;
  logic [7:0] pageMask;
  mdpp_pkg::mdpp_interp_t mainInterp;
  logic [3:0] chanInterp;
  logic [3:0] stageEn;
  logic [1:0] txReg;
  logic [2:0] syncMeta;
  logic [2:0] syncOut;
  logic [SAMPLE_W-1:0] sumI [2];
  logic [SAMPLE_W-1:0] sumQ [2];
  wire logic [7:0] dpRead [2];
  wire logic [7:0] gainOf [2];
  wire logic [1:0] irqReq;
  wire logic [1:0] blankRise;
  logic [3:0] repeatCnt;
  logic flushAll;
  logic sampleTake;
  logic mainBypass;
  logic fifoOutValid;
  logic fifoOutReady;
  logic [WORD_W-1:0] fifoOutData;
  logic [WORD_W-1:0] fifoInData;
  logic lastRepeat;

  // Scales a sample by the ramp gain, full scale being unity.
  function automatic logic [SAMPLE_W-1:0] scale(input logic [SAMPLE_W-1:0] s, input logic [7:0] g);
    logic signed [SAMPLE_W+8:0] prod;
    prod = $signed(s) * $signed({1'b0, g});
    return prod[`MDPP_GAIN_SHIFT +: SAMPLE_W];
  endfunction : scale

  // ==========================================
  // Pin synchronisers
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      syncMeta <= 3'h0;
      syncOut <= 3'h0;
    end
    else
    begin
      syncMeta <= {linkError, transmitEnableB, transmitEnableA};
      syncOut <= syncMeta;
    end
  end

  // ==========================================
  // Global controls
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      pageMask <= `MDPP_PAGE_RESET;
      mainInterp <= mdpp_pkg::MDPP_X1;
      chanInterp <= 4'h1;
      txReg <= 2'h0;
    end
    else if (regWrite)
    begin
      if (regAddr == `MDPP_ADDR_PAGE)
        pageMask <= regWdata;
      else if (regAddr == `MDPP_ADDR_MAIN_INTERP)
      begin
        case (regWdata[3:0])
          4'h1, 4'h2, 4'h4, 4'h6, 4'h8, 4'hc: mainInterp <= mdpp_pkg::mdpp_interp_t'(regWdata[3:0]);
          default: mainInterp <= mainInterp;
        endcase
      end
      else if (regAddr == `MDPP_ADDR_CHAN_INTERP)
        chanInterp <= regWdata[3:0];
      else if (regAddr == `MDPP_ADDR_TX_CTRL)
        txReg <= regWdata[1:0];
    end
  end

  // Active stages, bit order {last, second, third-band, first}; usable bandwidths are the
  // MDPP_BW_* values with MDPP_STOP_BAND_DB rejection each.
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      stageEn <= 4'h0;
    else
    begin
      case (mainInterp)
        mdpp_pkg::MDPP_X2: stageEn <= 4'h1;
        mdpp_pkg::MDPP_X4: stageEn <= 4'h5;
        mdpp_pkg::MDPP_X6: stageEn <= 4'h3;
        mdpp_pkg::MDPP_X8: stageEn <= 4'hd;
        mdpp_pkg::MDPP_X12: stageEn <= 4'h7;
        default: stageEn <= 4'h0;
      endcase
    end
  end

  // ==========================================
  // Summing node; with channel interpolation one only channel zero passes straight through.
  always_comb
  begin
    sumI[0] = chanI0[SAMPLE_W-1:0];
    sumQ[0] = chanQ0[SAMPLE_W-1:0];
    sumI[1] = chanI1[SAMPLE_W-1:0];
    sumQ[1] = chanQ1[SAMPLE_W-1:0];
    if (chanInterp != 4'h1)
    begin
      for (int c = 1; c < CHANNELS; c++)
      begin
        sumI[0] = sumI[0] + chanI0[c*SAMPLE_W +: SAMPLE_W];
        sumQ[0] = sumQ[0] + chanQ0[c*SAMPLE_W +: SAMPLE_W];
        sumI[1] = sumI[1] + chanI1[c*SAMPLE_W +: SAMPLE_W];
        sumQ[1] = sumQ[1] + chanQ1[c*SAMPLE_W +: SAMPLE_W];
      end
    end
  end

  assign mainBypass = (mainInterp == mdpp_pkg::MDPP_X1);
  assign sampleTake = sampleValid && sampleReady;
  assign flushAll = |blankRise;
  assign fifoInData = {sumQ[1], sumI[1], sumQ[0], sumI[0]};

  // ==========================================
  // Per-datapath controls, power detection, trip flags and gain ramp
  for (genvar dp = 0; dp < 2; dp++)
  begin : dpath
    logic [3:0] longExp;
    logic [1:0] shortExp;
    logic [12:0] longLimit;
    logic [12:0] shortLimit;
    logic [12:0] longPower;
    logic [12:0] shortPower;
    logic [3:0] rampEn;
    logic [3:0] irqEn;
    logic [3:0] flags;
    logic [1:0] outCtrl;
    logic [7:0] gain;
    logic [7:0] step;
    logic txPrev;
    logic powerTrip;
    logic [19:0] shortAcc;
    logic [7:0] shortCnt;
    logic [35:0] longAcc;
    logic [23:0] longCnt;
    logic [4:0] longShift;
    logic paged;
    logic txLevel;
    logic [3:0] events;
    logic [3:0] clearMask;
    logic [7:0] readV;
    logic signed [5:0] topI;
    logic signed [5:0] topQ;
    logic signed [11:0] sqI;
    logic signed [11:0] sqQ;
    logic [11:0] instPower;
    logic pdTake;
    logic wantOn;

    assign paged = pageMask[`MDPP_PAGE_DP0_BIT + dp];
    assign txLevel = syncOut[dp] | txReg[dp];
    assign topI = sumI[dp][SAMPLE_W-1 -: `MDPP_TOP_BITS];
    assign topQ = sumQ[dp][SAMPLE_W-1 -: `MDPP_TOP_BITS];
    assign sqI = topI * topI;
    assign sqQ = topQ * topQ;
    assign instPower = $unsigned(sqI) + $unsigned(sqQ);
    assign pdTake = sampleTake && !mainBypass;
    assign longShift = {1'b0, longExp} + `MDPP_LONG_EXP_BIAS;
    assign blankRise[dp] = txLevel && !txPrev;
    assign events[`MDPP_EV_POWER] = powerTrip;
    assign events[`MDPP_EV_LINK] = syncOut[2];
    assign events[`MDPP_EV_REG] = regWrite && paged && (regAddr == `MDPP_ADDR_PROTECT);
    assign events[`MDPP_EV_BLANK] = blankRise[dp];
    assign clearMask = (regWrite && paged && regAddr == `MDPP_ADDR_STATUS) ? regWdata[3:0] : 4'h0;
    assign irqReq[dp] = |(flags & irqEn);
    assign wantOn = outCtrl[`MDPP_OUT_ON_BIT] && !(|(flags & rampEn));
    assign step = outCtrl[`MDPP_OUT_QUICK_BIT] ? `MDPP_GAIN_FULL : 8'h01;
    assign gainOf[dp] = gain;
    assign dpRead[dp] = readV;

    always_ff @(posedge clock or negedge resetn)
    begin
      if (!resetn)
      begin
        longExp <= 4'h0;
        shortExp <= 2'h0;
        longLimit <= `MDPP_LIMIT_RESET;
        shortLimit <= `MDPP_LIMIT_RESET;
        rampEn <= 4'h0;
        irqEn <= 4'h0;
        outCtrl <= `MDPP_OUT_CTRL_RESET;
      end
      else if (regWrite && paged)
      begin
        if (regAddr == `MDPP_ADDR_LONG_EXP)
          longExp <= regWdata[3:0];
        else if (regAddr == `MDPP_ADDR_SHORT_EXP)
          shortExp <= regWdata[1:0];
        else if (regAddr == `MDPP_ADDR_LONG_LIM_LO)
          longLimit[7:0] <= regWdata;
        else if (regAddr == `MDPP_ADDR_LONG_LIM_HI)
          longLimit[12:8] <= regWdata[4:0];
        else if (regAddr == `MDPP_ADDR_SHORT_LIM_LO)
          shortLimit[7:0] <= regWdata;
        else if (regAddr == `MDPP_ADDR_SHORT_LIM_HI)
          shortLimit[12:8] <= regWdata[4:0];
        else if (regAddr == `MDPP_ADDR_RAMP_EN)
          rampEn <= regWdata[3:0];
        else if (regAddr == `MDPP_ADDR_IRQ_EN)
          irqEn <= regWdata[3:0];
        else if (regAddr == `MDPP_ADDR_OUT_CTRL)
          outCtrl <= regWdata[1:0];
      end
    end

    // Block averages over 2^shortExp and 2^(longExp+9) samples; a readback updates once per completed window.
    always_ff @(posedge clock or negedge resetn)
    begin
      if (!resetn)
      begin
        shortAcc <= 20'h0_0000;
        shortCnt <= 8'h00;
        shortPower <= 13'h0000;
        longAcc <= '0;
        longCnt <= '0;
        longPower <= 13'h0000;
      end
      else if (pdTake)
      begin
        // A window shortened while counting closes on the next sample instead of waiting for a wrap.
        if ({1'b0, shortCnt} >= (9'h001 << shortExp) - 9'h001)
        begin
          shortPower <= 13'((shortAcc + 20'(instPower)) >> shortExp);
          shortAcc <= 20'h0_0000;
          shortCnt <= 8'h00;
        end
        else
        begin
          shortAcc <= shortAcc + 20'(instPower);
          shortCnt <= shortCnt + 8'h01;
        end
        if ({1'b0, longCnt} >= (25'h000_0001 << longShift) - 25'h000_0001)
        begin
          longPower <= 13'((longAcc + 36'(instPower)) >> longShift);
          longAcc <= '0;
          longCnt <= '0;
        end
        else
        begin
          longAcc <= longAcc + 36'(instPower);
          longCnt <= longCnt + 24'h00_0001;
        end
      end
    end

    // Trip level, sticky flags (set beats clear) and transmit enable history.
    always_ff @(posedge clock or negedge resetn)
    begin
      if (!resetn)
      begin
        powerTrip <= 1'b0;
        flags <= 4'h0;
        txPrev <= 1'b0;
      end
      else
      begin
        powerTrip <= !mainBypass && (shortPower > shortLimit || longPower > longLimit);
        flags <= (flags & ~clearMask) | events;
        txPrev <= txLevel;
      end
    end

    always_ff @(posedge clock or negedge resetn)
    begin
      if (!resetn)
        gain <= `MDPP_GAIN_FULL;
      else if (wantOn)
        gain <= (gain >= `MDPP_GAIN_FULL - step) ? `MDPP_GAIN_FULL : gain + step;
      else
        gain <= (gain <= step) ? 8'h00 : gain - step;
    end

    always_comb
    begin
      readV = 8'h00;
      if (regAddr == `MDPP_ADDR_LONG_EXP)
        readV = {4'h0, longExp};
      else if (regAddr == `MDPP_ADDR_SHORT_EXP)
        readV = {6'h00, shortExp};
      else if (regAddr == `MDPP_ADDR_LONG_LIM_LO)
        readV = longLimit[7:0];
      else if (regAddr == `MDPP_ADDR_LONG_LIM_HI)
        readV = {3'h0, longLimit[12:8]};
      else if (regAddr == `MDPP_ADDR_LONG_PWR_LO)
        readV = longPower[7:0];
      else if (regAddr == `MDPP_ADDR_LONG_PWR_HI)
        readV = {3'h0, longPower[12:8]};
      else if (regAddr == `MDPP_ADDR_SHORT_LIM_LO)
        readV = shortLimit[7:0];
      else if (regAddr == `MDPP_ADDR_SHORT_LIM_HI)
        readV = {3'h0, shortLimit[12:8]};
      else if (regAddr == `MDPP_ADDR_SHORT_PWR_LO)
        readV = shortPower[7:0];
      else if (regAddr == `MDPP_ADDR_SHORT_PWR_HI)
        readV = {3'h0, shortPower[12:8]};
      else if (regAddr == `MDPP_ADDR_RAMP_EN)
        readV = {4'h0, rampEn};
      else if (regAddr == `MDPP_ADDR_IRQ_EN)
        readV = {4'h0, irqEn};
      else if (regAddr == `MDPP_ADDR_STATUS)
        readV = {4'h0, flags};
      else if (regAddr == `MDPP_ADDR_OUT_CTRL)
        readV = {6'h00, outCtrl};
    end
  end

  // ==========================================
  // Sample buffer
  mdpp_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(FIFO_DEPTH)
  ) u_mdpp_fifo (
    .clock(clock),
    .resetn(resetn),
    .flush(flushAll),
    .inValid(sampleValid),
    .inReady(sampleReady),
    .inData(fifoInData),
    .outValid(fifoOutValid),
    .outReady(fifoOutReady),
    .outData(fifoOutData)
  );

  // ==========================================
  // Output pacing: each word is held for as many DAC beats as the interpolation factor.
  assign lastRepeat = (repeatCnt == 4'(mainInterp) - 4'h1);
  assign fifoOutReady = !dacValid || (dacReady && lastRepeat);

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      dacValid <= 1'b0;
      repeatCnt <= 4'h0;
      dacI0 <= '0;
      dacQ0 <= '0;
      dacI1 <= '0;
      dacQ1 <= '0;
    end
    else if (flushAll)
    begin
      dacValid <= 1'b0;
      repeatCnt <= 4'h0;
    end
    else if (fifoOutValid && fifoOutReady)
    begin
      dacValid <= 1'b1;
      repeatCnt <= 4'h0;
      if (mainBypass)
      begin
        {dacQ1, dacI1, dacQ0, dacI0} <= fifoOutData;
      end
      else
      begin
        dacI0 <= scale(fifoOutData[0*SAMPLE_W +: SAMPLE_W], gainOf[0]);
        dacQ0 <= scale(fifoOutData[1*SAMPLE_W +: SAMPLE_W], gainOf[0]);
        dacI1 <= scale(fifoOutData[2*SAMPLE_W +: SAMPLE_W], gainOf[1]);
        dacQ1 <= scale(fifoOutData[3*SAMPLE_W +: SAMPLE_W], gainOf[1]);
      end
    end
    else if (dacValid && dacReady)
    begin
      if (lastRepeat)
        dacValid <= 1'b0;
      else
        repeatCnt <= repeatCnt + 4'h1;
    end
  end

  // ==========================================
  // Register readback and interrupt pins
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      regRdata <= 8'h00;
      interruptPinA_n <= 1'b1;
      interruptPinB_n <= 1'b1;
    end
    else
    begin
      interruptPinA_n <= !irqReq[0];
      interruptPinB_n <= !irqReq[1];
      if (regAddr == `MDPP_ADDR_PAGE)
        regRdata <= pageMask;
      else if (regAddr == `MDPP_ADDR_MAIN_INTERP)
        regRdata <= {stageEn, 4'(mainInterp)};
      else if (regAddr == `MDPP_ADDR_CHAN_INTERP)
        regRdata <= {4'h0, chanInterp};
      else if (regAddr == `MDPP_ADDR_TX_CTRL)
        regRdata <= {6'h00, txReg};
      else if (pageMask[`MDPP_PAGE_DP0_BIT])
        regRdata <= dpRead[0];
      else
        regRdata <= dpRead[1];
    end
  end
endmodule : mdpp_top

// File: mdpp_top_assertions.sv
// Checker for the datapath front end; it sees only the top module's ports.
// Assumes it is bound to every instance of mdpp_top.
`timescale 1ns/100ps
`include "mdpp_params.svh"
module mdpp_top_chk #(
  parameter int SAMPLE_W = 16
)(
  input wire logic clock,
  input wire logic resetn,
  input wire logic regWrite,
  input wire logic [11:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic [7:0] regRdata,
  input wire logic sampleValid,
  input wire logic sampleReady,
  input wire logic dacValid,
  input wire logic dacReady,
  input wire logic [SAMPLE_W-1:0] dacI0,
  input wire logic interruptPinA_n,
  input wire logic interruptPinB_n
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  // ==========
  // Port relations
  chk_reset_pins: assert property ($rose(resetn) |-> interruptPinA_n && interruptPinB_n && !dacValid)
    else $error("pins or valid active right after reset");
  chk_ready_wake: assert property ($rose(resetn) |=> sampleReady)
    else $error("sample ready not raised after reset");
  chk_ready_no_take: assert property (sampleReady && !sampleValid |=> sampleReady)
    else $error("sample ready dropped without a take");
  chk_unmapped_zero: assert property (regAddr == 12'h100 |=> regRdata == 8'h00)
    else $error("unmapped address read nonzero");
  chk_limit_readback: assert property (regWrite && regAddr == `MDPP_ADDR_LONG_LIM_LO ##1
    !regWrite && regAddr == `MDPP_ADDR_LONG_LIM_LO |=> regRdata == $past(regWdata, 2))
    else $error("limit low byte not read back");
  chk_interp_refuse: assert property (regWrite && regAddr == `MDPP_ADDR_MAIN_INTERP && regWdata == 8'h03 ##1
    !regWrite && regAddr == `MDPP_ADDR_MAIN_INTERP |=> $stable(regRdata))
    else $error("illegal interpolation factor accepted");
  chk_dac_hold: assert property (dacValid && !dacReady |=> dacValid && $stable(dacI0))
    else $error("output beat changed while stalled");
  chk_dac_latency: assert property (sampleValid && sampleReady && !dacValid |-> ##[1:2] dacValid)
    else $error("taken sample did not reach the output in time");
endmodule : mdpp_top_chk
bind mdpp_top mdpp_top_chk #(.SAMPLE_W(SAMPLE_W)) u_mdpp_top_chk (.*);

// File: tb_mdpp_top.sv
// Self-checking bench for mdpp_top: register rows, datapath, protection and reset.
// Assumes the DAC sink model and the bound checker.
`timescale 1ns/100ps
`include "mdpp_params.svh"
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin error_cnt++; $display("Error %s exp %h got %h", n, e, s); end end
module tb_mdpp_top;
  typedef struct {logic w; logic [11:0] a; logic [7:0] d; logic [7:0] e;} mdpp_row_t;
  logic clock = 0, resetn = 0, regWrite = 0, sampleValid = 0, dacStall = 0;
  logic txA = 0, linkError = 0;
  logic [11:0] regAddr = 0;
  logic [7:0] regWdata = 0, regRdata;
  logic [47:0] chanI0 = 0;
  logic sampleReady, dacValid, dacReady, pinA_n, pinB_n;
  logic [15:0] dacI0, lastI, dacQ0, dacI1, dacQ1;
  int error_cnt = 0, checks = 0, beats, n, b0;
  mdpp_row_t rows [16] = '{'{0, `MDPP_ADDR_PAGE, 0, 8'h40}, '{0, `MDPP_ADDR_LONG_LIM_HI, 0, 8'h1F},
    '{0, `MDPP_ADDR_OUT_CTRL, 0, 8'h01}, '{0, `MDPP_ADDR_MAIN_INTERP, 0, 8'h01},
    '{1, `MDPP_ADDR_LONG_LIM_LO, 8'hA5, 8'hA5}, '{1, `MDPP_ADDR_SHORT_LIM_HI, 8'hFF, 8'h1F},
    '{1, `MDPP_ADDR_LONG_EXP, 8'h03, 8'h03}, '{1, `MDPP_ADDR_SHORT_EXP, 8'h02, 8'h02},
    '{1, 12'h100, 8'h55, 8'h00}, '{1, `MDPP_ADDR_LONG_PWR_LO, 8'h77, 8'h00},
    '{1, `MDPP_ADDR_MAIN_INTERP, 8'h02, 8'h12}, '{1, `MDPP_ADDR_MAIN_INTERP, 8'h04, 8'h54},
    '{1, `MDPP_ADDR_MAIN_INTERP, 8'h06, 8'h36}, '{1, `MDPP_ADDR_MAIN_INTERP, 8'h08, 8'hD8},
    '{1, `MDPP_ADDR_MAIN_INTERP, 8'h0C, 8'h7C}, '{1, `MDPP_ADDR_MAIN_INTERP, 8'h03, 8'h7C}};
  mdpp_top u_mdpp_top (.clock(clock), .resetn(resetn), .regWrite(regWrite), .regAddr(regAddr),
    .regWdata(regWdata), .regRdata(regRdata), .sampleValid(sampleValid), .sampleReady(sampleReady),
    .chanI0(chanI0), .chanQ0(48'h0000_0000_0000), .chanI1(48'h0000_0000_0000), .chanQ1(48'h0000_0000_0000),
    .transmitEnableA(txA), .transmitEnableB(1'b0), .linkError(linkError), .dacValid(dacValid),
    .dacReady(dacReady), .dacI0(dacI0), .dacQ0(dacQ0), .dacI1(dacI1), .dacQ1(dacQ1), .interruptPinA_n(pinA_n),
    .interruptPinB_n(pinB_n));
  mdpp_dac_sink u_mdpp_dac_sink (.clock(clock), .stall(dacStall), .dacValid(dacValid), .dacReady(dacReady),
    .dacI0(dacI0), .beats(beats), .lastI(lastI));
  // ==========
  // Tasks
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge clock);
    regAddr = a;
    regWdata = d;
    regWrite = 1'b1;
    @(negedge clock);
    regWrite = 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    @(negedge clock);
    regAddr = a;
    @(negedge clock);
    `CHK("reg", e, regRdata)
  endtask : rd
  task automatic send(input logic [47:0] i, input int k);
    @(negedge clock);
    chanI0 = i;
    sampleValid = 1'b1;
    repeat (k)
    begin
      while (sampleReady !== 1'b1)
        @(negedge clock);
      @(negedge clock);
    end
    sampleValid = 1'b0;
  endtask : send
  task automatic close_out;
    if (error_cnt == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : close_out
  initial
  begin
    forever #2.5 clock = ~clock;
  end
  initial
  begin
    repeat (5000) @(posedge clock);
    error_cnt++;
    close_out();
  end
  initial
  begin
    repeat (10) @(negedge clock);
    resetn = 1'b1;
    foreach (rows[i])
    begin
      if (rows[i].w)
        wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e);
    end
    wr(`MDPP_ADDR_PAGE, 8'h80);
    wr(`MDPP_ADDR_LONG_LIM_LO, 8'h11);
    rd(`MDPP_ADDR_LONG_LIM_LO, 8'h11);
    wr(`MDPP_ADDR_PAGE, 8'h40);
    rd(`MDPP_ADDR_LONG_LIM_LO, 8'hA5);
    wr(`MDPP_ADDR_PAGE, 8'hC0);
    wr(`MDPP_ADDR_LONG_LIM_LO, 8'h22);
    wr(`MDPP_ADDR_PAGE, 8'h80);
    rd(`MDPP_ADDR_LONG_LIM_LO, 8'h22);
    wr(`MDPP_ADDR_MAIN_INTERP, 8'h01);
    send(48'h0003_0002_0001, 1);
    repeat (6) @(negedge clock);
    `CHK("bypass", 16'h0001, lastI)
    wr(`MDPP_ADDR_CHAN_INTERP, 8'h02);
    send(48'h0003_0002_0001, 1);
    repeat (6) @(negedge clock);
    `CHK("sum", 16'h0006, lastI)
    dacStall = 1'b1;
    n = 0;
    @(negedge clock);
    chanI0 = 48'h0000_0000_0100;
    sampleValid = 1'b1;
    repeat (14)
    begin
      if (sampleReady === 1'b1)
        n++;
      @(negedge clock);
    end
    sampleValid = 1'b0;
    `CHK("taken", 9, n)
    b0 = beats;
    dacStall = 1'b0;
    repeat (20) @(negedge clock);
    `CHK("drained", b0 + 9, beats)
    wr(`MDPP_ADDR_MAIN_INTERP, 8'h02);
    b0 = beats;
    send(48'h0000_0000_0123, 3);
    repeat (12) @(negedge clock);
    `CHK("beats", b0 + 6, beats)
    `CHK("gain", 16'h0123, lastI)
    `CHK("others", 48'h0000_0000_0000, {dacQ0, dacI1, dacQ1})
    wr(`MDPP_ADDR_PAGE, 8'h40);
    wr(`MDPP_ADDR_SHORT_EXP, 8'h00);
    wr(`MDPP_ADDR_SHORT_LIM_LO, 8'h10);
    wr(`MDPP_ADDR_SHORT_LIM_HI, 8'h00);
    wr(`MDPP_ADDR_IRQ_EN, 8'h01);
    send(48'h0000_0000_7FFF, 1);
    repeat (8) @(negedge clock);
    `CHK("pinA", 1'b0, pinA_n)
    `CHK("pinB", 1'b1, pinB_n)
    rd(`MDPP_ADDR_SHORT_PWR_LO, 8'hC1);
    rd(`MDPP_ADDR_SHORT_PWR_HI, 8'h03);
    rd(`MDPP_ADDR_STATUS, 8'h01);
    wr(`MDPP_ADDR_SHORT_LIM_HI, 8'h1F);
    wr(`MDPP_ADDR_STATUS, 8'h01);
    rd(`MDPP_ADDR_STATUS, 8'h00);
    wr(`MDPP_ADDR_PAGE, 8'h80);
    wr(`MDPP_ADDR_IRQ_EN, 8'h04);
    wr(`MDPP_ADDR_PROTECT, 8'h01);
    repeat (3) @(negedge clock);
    `CHK("pinB", 1'b0, pinB_n)
    linkError = 1'b1;
    repeat (5) @(negedge clock);
    linkError = 1'b0;
    rd(`MDPP_ADDR_STATUS, 8'h06);
    txA = 1'b1;
    wr(`MDPP_ADDR_TX_CTRL, 8'h02);
    repeat (4) @(negedge clock);
    rd(`MDPP_ADDR_STATUS, 8'h0E);
    wr(`MDPP_ADDR_PAGE, 8'h40);
    rd(`MDPP_ADDR_STATUS, 8'h0A);
    resetn = 1'b0;
    @(negedge clock);
    `CHK("reset", 12'hC00, {pinA_n, pinB_n, dacValid, sampleReady, regRdata})
    resetn = 1'b1;
    rd(`MDPP_ADDR_PAGE, 8'h40);
    close_out();
  end
endmodule : tb_mdpp_top
